// File: logic/ffo_defines.svh
// Offsets, field positions, reset values and counts of the FIFO flag block
`ifndef FFO_DEFINES_SVH
`define FFO_DEFINES_SVH

`define FFO_AW_DEFAULT       14
`define FFO_DATA_W           9
`define FFO_LO_W             8
`define FFO_OFS_DEF_PARALLEL 16'h007F
`define FFO_OFS_DEF_SERIAL   16'h03FF
`define FFO_VALID_EDGES      2'h2

`define FFO_ADDR_W           12
`define FFO_REG_STATUS       12'h000
`define FFO_REG_OFFSETS      12'h004
`define FFO_REG_CTRL         12'h008

`define FFO_CTRL_PRST_BIT    0
`define FFO_STAT_FIRST_WORD_FALLTHROUGH_SEL_BIT    31
`define FFO_STAT_SERIAL_BIT  30
`define FFO_STAT_PEND_W_BIT  29
`define FFO_STAT_PEND_R_BIT  28

`endif

// File: logic/ffo_pkg.sv
// Types shared by the FIFO flag block
package ffo_pkg;

   typedef logic [1:0] ffo_seq_t;

   typedef enum logic {
      FFO_PARALLEL_LOAD,
      FFO_SERIAL_LOAD
   } ffo_load_t;

   typedef enum logic {
      FFO_STANDARD,
      FFO_FALLTHROUGH
   } ffo_timing_t;

endpackage : ffo_pkg

// File: logic/ffo_flags.sv
// FIFO with status flags, flag offset programming and an APB status port
// Contract
// - Standard: empty_flag_n low only at zero; almost_empty_n low up to n words.
// - Standard: almost_full_n low from D minus m; full_flag_n low at exactly D.
// - Fall-through: half_full_n low from D/2+2; almost_full_n low from D+1-m.
// - Fall-through: ready-out low if nonempty, almost_empty_n to n+1, input_ready_n at D+1.
// - Both offsets default to 127 for parallel, 1023 for serial loading.
// - Loading method is fixed only during master reset.
// - Parallel write stores data into next offset register, empty low byte first.
// - Parallel read presents next offset register on read_data_out, empty low byte first.
// - Serial loading shifts one bit per write edge, empty low bit to full high bit.
// - Load select low with serial enable high performs no serial write.
// - Memory writes accepted with load select and serial enable high.
// - Serial bit position survives interruptions and resumes with next bit.
// - New offsets reach the flags two write or read edges after loading ends.
// - Offsets are readable through the parallel read sequence and the APB offsets register.
// - Parallel offset read allowed whatever loading method was chosen.
// - Offset decoding is identical in standard and fall-through timing.
// - Fall-through select high at master reset selects fall-through timing.
// - Load select high at master reset selects serial loading, low parallel.
// - Master reset zeroes both sequence pointers; partial reset keeps them.
`timescale 1ns/100ps
`include "ffo_defines.svh"

module ffo_flags
   import ffo_pkg::*;
#(
   parameter int AW = `FFO_AW_DEFAULT
) (
   input  wire logic                     ref_clk,
   input  wire logic                     reset,
   input  wire logic                     write_clock,
   input  wire logic                     read_clock,
   input  wire logic                     write_enable_n,
   input  wire logic                     read_enable_n,
   input  wire logic                     load_select_n,
   input  wire logic                     serial_enable_n,
   input  wire logic                     first_word_fallthrough_sel_serial_in,
   input  wire logic                     master_reset_n,
   input  wire logic [`FFO_DATA_W-1:0]   write_data_in,
   output logic      [`FFO_DATA_W-1:0]   read_data_out,
   output logic                          full_flag_n,
   output logic                          input_ready_n,
   output logic                          empty_flag_n,
   output logic                          output_ready_n,
   output logic                          almost_full_n,
   output logic                          almost_empty_n,
   output logic                          half_full_n,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`FFO_ADDR_W-1:0]   paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr
);

   localparam int DW    = `FFO_DATA_W;
   localparam int LW    = `FFO_LO_W;
   localparam int HW    = AW - LW;
   localparam int CW    = AW + 2;
   localparam int SW    = DW + 8;
   localparam int DEPTH = 1 << AW;
   localparam logic [CW-1:0] CAP_STD  = CW'(DEPTH);
   localparam logic [CW-1:0] CAP_FALL = CW'(DEPTH + 1);
   localparam logic [CW-1:0] HALF     = CW'(DEPTH / 2);
   localparam logic [AW:0]   MEM_FULL = (AW + 1)'(DEPTH);
   localparam logic [5:0]    SER_LAST = 6'(2 * AW - 1);

   // Pin synchroniser; pins are sampled, clocks become edge strobes
   logic [SW-1:0]        sync1;
   logic [SW-1:0]        sync2;
   logic                 wclk_d;
   logic                 rclk_d;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {write_data_in, write_clock, read_clock, write_enable_n, read_enable_n,
                   load_select_n, serial_enable_n, first_word_fallthrough_sel_serial_in, master_reset_n};
         sync2 <= sync1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         wclk_d <= 1'b0;
         rclk_d <= 1'b0;
      end else begin
         wclk_d <= sync2[7];
         rclk_d <= sync2[6];
      end
   end

   wire [DW-1:0] s_data  = sync2[SW-1:8];
   wire          s_wclk  = sync2[7];
   wire          s_rclk  = sync2[6];
   wire          s_wen_n = sync2[5];
   wire          s_ren_n = sync2[4];
   wire          s_ld_n  = sync2[3];
   wire          s_sen_n = sync2[2];
   wire          s_si    = sync2[1];
   wire          s_mr_n  = sync2[0];
   wire          w_edge  = s_wclk & ~wclk_d;
   wire          r_edge  = s_rclk & ~rclk_d;
   wire          mr      = ~s_mr_n;

   // State
   ffo_timing_t          timing;
   ffo_load_t            load_mode;
   logic [2*AW-1:0]      ofs_all;
   logic [AW-1:0]        act_empty;
   logic [AW-1:0]        act_full;
   ffo_seq_t             wseq;
   ffo_seq_t             rseq;
   logic [5:0]           ser_pos;
   logic [1:0]           pend_w;
   logic [1:0]           pend_r;
   logic [AW-1:0]        wr_ptr;
   logic [AW-1:0]        rd_ptr;
   logic [AW:0]          mem_cnt;
   logic                 out_valid;
   logic [DW-1:0]        mem [DEPTH];
   logic [2*AW-1:0]      next_ofs;

   wire [AW-1:0] ofs_empty = ofs_all[AW-1:0];
   wire [AW-1:0] ofs_full  = ofs_all[2*AW-1:AW];
   wire          fall      = (timing == FFO_FALLTHROUGH);
   wire          serial    = (load_mode == FFO_SERIAL_LOAD);

   // APB decode; partial reset empties the FIFO but keeps offsets and sequence pointers
   wire apb_acc    = psel & penable & ~pready;
   wire apb_done   = psel & penable & pready;
   wire hit_status = (paddr == `FFO_REG_STATUS);
   wire hit_ofs    = (paddr == `FFO_REG_OFFSETS);
   wire hit_ctrl   = (paddr == `FFO_REG_CTRL);
   wire hit_any    = hit_status | hit_ofs | hit_ctrl;
   wire part_rst   = apb_done & pwrite & hit_ctrl & pwdata[`FFO_CTRL_PRST_BIT];

   // Control decoding, the same in both timing modes
   wire par_wr  = w_edge & ~s_ld_n & ~s_wen_n & s_ren_n & s_sen_n & ~serial;
   wire ser_sh  = w_edge & ~s_ld_n & ~s_sen_n & s_wen_n & s_ren_n & serial;
   wire par_rd  = r_edge & ~s_ld_n & ~s_ren_n & s_wen_n & s_sen_n;
   wire rd_req  = r_edge & s_ld_n & ~s_ren_n;

   // Occupancy; fall-through adds the output register as one more word
   wire [CW-1:0] cnt      = CW'(mem_cnt) + CW'(out_valid);
   wire [CW-1:0] cap      = fall ? CAP_FALL : CAP_STD;
   wire          full_now = (cnt == cap) | (mem_cnt == MEM_FULL);
   wire          mem_wr   = w_edge & s_ld_n & ~s_wen_n & ~full_now;
   wire          mem_any  = (mem_cnt != '0);
   wire          std_rd   = rd_req & ~fall & mem_any;
   wire          fw_pop   = rd_req & fall & out_valid;
   wire          fw_fill  = fall & mem_any & (~out_valid | fw_pop) & ~par_rd;
   wire          mem_pop  = std_rd | fw_fill;
   wire          ser_done = ser_sh & (ser_pos == SER_LAST);
   wire          load_end = ser_done | par_wr;

   wire [AW-1:0] def_ofs  = s_ld_n ? AW'(`FFO_OFS_DEF_SERIAL)
                                   : AW'(`FFO_OFS_DEF_PARALLEL);

   // Offset register layout: low byte then high part, empty then full
   always_comb begin
      next_ofs = ofs_all;
      if (ser_sh) begin
         next_ofs[ser_pos[$clog2(2*AW)-1:0]] = s_si;
      end
      if (par_wr) begin
         unique case (wseq)
            2'h0: next_ofs[LW-1:0]       = s_data[LW-1:0];
            2'h1: next_ofs[AW-1:LW]      = s_data[HW-1:0];
            2'h2: next_ofs[AW+LW-1:AW]   = s_data[LW-1:0];
            2'h3: next_ofs[2*AW-1:AW+LW] = s_data[HW-1:0];
         endcase
      end
   end

   logic [DW-1:0] ofs_word;
   always_comb begin
      unique case (rseq)
         2'h0: ofs_word = DW'(ofs_empty[LW-1:0]);
         2'h1: ofs_word = DW'(ofs_empty[AW-1:LW]);
         2'h2: ofs_word = DW'(ofs_full[LW-1:0]);
         2'h3: ofs_word = DW'(ofs_full[AW-1:LW]);
      endcase
   end

   // Mode capture is held open for the whole master reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         timing    <= FFO_STANDARD;
         load_mode <= FFO_PARALLEL_LOAD;
      end else if (mr) begin
         timing    <= s_si ? FFO_FALLTHROUGH : FFO_STANDARD;
         load_mode <= s_ld_n ? FFO_SERIAL_LOAD : FFO_PARALLEL_LOAD;
      end
   end

   // Offsets and sequence pointers
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ofs_all <= {2{AW'(`FFO_OFS_DEF_PARALLEL)}};
         wseq    <= 2'h0;
         rseq    <= 2'h0;
         ser_pos <= 6'h00;
      end else if (mr) begin
         ofs_all <= {def_ofs, def_ofs};
         wseq    <= 2'h0;
         rseq    <= 2'h0;
         ser_pos <= 6'h00;
      end else begin
         ofs_all <= next_ofs;
         if (par_wr) begin
            wseq <= wseq + 2'h1;
         end
         if (par_rd) begin
            rseq <= rseq + 2'h1;
         end
         if (ser_sh) begin
            // Position held while either enable is low; a full set always wraps
            ser_pos <= ser_done ? 6'h00 : ser_pos + 6'h01;
         end
      end
   end

   // Flags switch to new offsets only after two edges of their own side
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         act_empty <= AW'(`FFO_OFS_DEF_PARALLEL);
         act_full  <= AW'(`FFO_OFS_DEF_PARALLEL);
         pend_w    <= 2'h0;
         pend_r    <= 2'h0;
      end else if (mr) begin
         act_empty <= def_ofs;
         act_full  <= def_ofs;
         pend_w    <= 2'h0;
         pend_r    <= 2'h0;
      end else begin
         if (load_end) begin
            pend_w <= `FFO_VALID_EDGES;
         end else if (w_edge && pend_w != 2'h0) begin
            pend_w <= pend_w - 2'h1;
            if (pend_w == 2'h1) begin
               act_full <= ofs_full;
            end
         end
         if (load_end) begin
            pend_r <= `FFO_VALID_EDGES;
         end else if (r_edge && pend_r != 2'h0) begin
            pend_r <= pend_r - 2'h1;
            if (pend_r == 2'h1) begin
               act_empty <= ofs_empty;
            end
         end
      end
   end

   // Storage has no reset; only pointers and counts are cleared
   always_ff @(posedge ref_clk) begin
      if (mem_wr) begin
         mem[wr_ptr] <= s_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset || mr || part_rst) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         mem_cnt   <= '0;
         out_valid <= 1'b0;
      end else begin
         if (mem_wr) begin
            wr_ptr <= wr_ptr + AW'(1);
         end
         if (mem_pop) begin
            rd_ptr <= rd_ptr + AW'(1);
         end
         mem_cnt <= mem_cnt + (AW + 1)'(mem_wr) - (AW + 1)'(mem_pop);
         if (fw_fill) begin
            out_valid <= 1'b1;
         end else if (fw_pop) begin
            out_valid <= 1'b0;
         end
      end
   end

   // An offset read overwrites whatever word was on the output
   always_ff @(posedge ref_clk) begin
      if (reset || mr) begin
         read_data_out <= '0;
      end else if (par_rd) begin
         read_data_out <= ofs_word;
      end else if (mem_pop) begin
         read_data_out <= mem[rd_ptr];
      end
   end

   // Flag thresholds
   wire [CW-1:0] n_e      = CW'(act_empty);
   wire [CW-1:0] m_f      = CW'(act_full);
   wire          next_ef  = fall | (cnt != '0);
   wire          next_ff  = fall | (cnt != CAP_STD);
   wire          next_or  = ~fall | (cnt == '0);
   wire          next_ir  = ~fall | (cnt == CAP_FALL);
   wire          next_ae  = fall ? (cnt > n_e + CW'(1)) : (cnt > n_e);
   wire          next_hf  = fall ? (cnt <= HALF + CW'(1)) : (cnt <= HALF);
   wire          next_af  = fall ? (cnt < CAP_FALL - m_f) : (cnt < CAP_STD - m_f);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         empty_flag_n   <= 1'b0;
         full_flag_n    <= 1'b1;
         output_ready_n <= 1'b1;
         input_ready_n  <= 1'b1;
         almost_empty_n <= 1'b0;
         half_full_n    <= 1'b1;
         almost_full_n  <= 1'b1;
      end else begin
         empty_flag_n   <= next_ef;
         full_flag_n    <= next_ff;
         output_ready_n <= next_or;
         input_ready_n  <= next_ir;
         almost_empty_n <= next_ae;
         half_full_n    <= next_hf;
         almost_full_n  <= next_af;
      end
   end

   // APB slave: one wait state, error on unmapped address
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_status) begin
         rd_mux = 32'(cnt);
         rd_mux[`FFO_STAT_FIRST_WORD_FALLTHROUGH_SEL_BIT]   = fall;
         rd_mux[`FFO_STAT_SERIAL_BIT] = serial;
         rd_mux[`FFO_STAT_PEND_W_BIT] = (pend_w != 2'h0);
         rd_mux[`FFO_STAT_PEND_R_BIT] = (pend_r != 2'h0);
      end else if (hit_ofs) begin
         rd_mux = 32'(ofs_all);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apb_acc;
         pslverr <= apb_acc & ~hit_any;
         prdata  <= (apb_acc & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

endmodule : ffo_flags

// File: sim/ffo_flags_chk.sv
// Port assertions for the FIFO flag block
`timescale 1ns/100ps
`include "ffo_defines.svh"
module ffo_flags_chk (
   input wire logic                   ref_clk,
   input wire logic                   reset,
   input wire logic                   master_reset_n,
   input wire logic                   full_flag_n,
   input wire logic                   empty_flag_n,
   input wire logic                   output_ready_n,
   input wire logic                   almost_full_n,
   input wire logic                   almost_empty_n,
   input wire logic                   half_full_n,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic [`FFO_ADDR_W-1:0] paddr,
   input wire logic                   pready,
   input wire logic                   pslverr
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   sequence s_access; psel && penable && !pready; endsequence
   sequence s_answer; pready ##1 !pready; endsequence
   property p_wait_one; s_access |=> s_answer; endproperty
   property p_unmapped;
      psel && penable && !pready
      && !(paddr inside {`FFO_REG_STATUS, `FFO_REG_OFFSETS, `FFO_REG_CTRL})
      |=> pslverr && pready;
   endproperty
   property p_err_ready; pslverr |-> pready; endproperty
   property p_empty_ae; !empty_flag_n |-> !almost_empty_n; endproperty
   property p_full_af; !full_flag_n |-> !almost_full_n && !half_full_n; endproperty
   property p_empty_quiet; !empty_flag_n |-> full_flag_n && half_full_n; endproperty
   property p_pair_excl; !output_ready_n |-> empty_flag_n && full_flag_n; endproperty
   // Long hold gives the synchroniser and flag registers time to settle
   property p_mrst; !master_reset_n [*8] |-> almost_full_n && half_full_n; endproperty
   a_wait_one: assert property (p_wait_one) else $error("pready not one cycle late");
   a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");
   a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
   a_empty_ae: assert property (p_empty_ae) else $error("ae high when empty");
   a_full_af: assert property (p_full_af) else $error("full without upper flags");
   a_empty_quiet: assert property (p_empty_quiet) else $error("upper flags empty");
   a_pair_excl: assert property (p_pair_excl) else $error("flag pairs overlap");
   a_mrst: assert property (p_mrst) else $error("upper flags low in master reset");
endmodule : ffo_flags_chk

bind ffo_flags ffo_flags_chk u_ffo_flags_chk (.ref_clk, .reset, .master_reset_n, .full_flag_n,
   .empty_flag_n, .output_ready_n, .almost_full_n, .almost_empty_n, .half_full_n, .psel,
   .penable, .paddr, .pready, .pslverr);

// File: sim/ffo_ctrl_model.sv
// Behavioural controller driving the FIFO pin ports
`timescale 1ns/100ps
module ffo_ctrl_model (
   input  wire logic       ref_clk,
   output logic            write_clock,
   output logic            read_clock,
   output logic            write_enable_n,
   output logic            read_enable_n,
   output logic            load_select_n,
   output logic            serial_enable_n,
   output logic            first_word_fallthrough_sel_serial_in,
   output logic            master_reset_n,
   output logic [8:0]      write_data_in
);
   initial begin
      {write_clock, read_clock, first_word_fallthrough_sel_serial_in, master_reset_n} = 4'h0;
      {write_enable_n, read_enable_n, serial_enable_n, load_select_n} = 4'hF;
      write_data_in = 9'h000;
   end
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : idle
   task automatic mreset(input logic ld, input logic fw);
      @(posedge ref_clk);
      master_reset_n <= 1'b0;
      load_select_n <= ld;
      first_word_fallthrough_sel_serial_in <= fw;
      idle(10);
      master_reset_n <= 1'b1;
      idle(6);
   endtask : mreset
   // Controls stay put three cycles around each pin edge for the synchroniser
   task automatic pulse(input logic wr, input logic [3:0] ctl, input logic si,
                        input logic [8:0] d);
      @(posedge ref_clk);
      {load_select_n, write_enable_n, read_enable_n, serial_enable_n} <= ctl;
      first_word_fallthrough_sel_serial_in <= si;
      write_data_in <= d;
      idle(3);
      if (wr) write_clock <= 1'b1;
      else read_clock <= 1'b1;
      idle(3);
      write_clock <= 1'b0;
      read_clock <= 1'b0;
      idle(3);
      {write_enable_n, read_enable_n, serial_enable_n} <= 3'h7;
      write_data_in <= ~d;
   endtask : pulse
endmodule : ffo_ctrl_model

// File: sim/ffo_flags_bench.sv
// Self-checking bench for the FIFO flag block
`timescale 1ns/100ps
`include "ffo_defines.svh"
module ffo_flags_bench;
   import ffo_pkg::*;
   localparam int AW = 9;
   localparam int D  = 1 << AW;
   logic        ref_clk, reset, psel, penable, pwrite, pready, pslverr, err;
   logic        write_clock, read_clock, write_enable_n, read_enable_n, load_select_n;
   logic        serial_enable_n, first_word_fallthrough_sel_serial_in, master_reset_n, full_flag_n, input_ready_n;
   logic        empty_flag_n, output_ready_n, almost_full_n, almost_empty_n, half_full_n;
   logic [8:0]  write_data_in, read_data_out;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int          num_errors, n_checks, cycles;

   ffo_flags #(.AW(AW)) u_ffo_flags (.ref_clk, .reset, .write_clock, .read_clock,
      .write_enable_n, .read_enable_n, .load_select_n, .serial_enable_n, .first_word_fallthrough_sel_serial_in,
      .master_reset_n, .write_data_in, .read_data_out, .full_flag_n, .input_ready_n,
      .empty_flag_n, .output_ready_n, .almost_full_n, .almost_empty_n, .half_full_n,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   ffo_ctrl_model u_ffo_ctrl_model (.ref_clk, .write_clock, .read_clock, .write_enable_n,
      .read_enable_n, .load_select_n, .serial_enable_n, .first_word_fallthrough_sel_serial_in, .master_reset_n,
      .write_data_in);

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("Checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Waits on pready alone; only the cycle ceiling ends a hang
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {psel, pwrite, paddr, pwdata, penable} <= {1'b1, w, a, d, 1'b0};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [6:0] seen(input logic fw);
      if (fw) return {input_ready_n, almost_full_n, half_full_n, almost_empty_n,
                      output_ready_n, full_flag_n, empty_flag_n};
      return {full_flag_n, almost_full_n, half_full_n, almost_empty_n, empty_flag_n,
              input_ready_n, output_ready_n};
   endfunction : seen
   function automatic logic [6:0] exp_flags(input logic fw, input int k, n, m);
      if (fw) return {k == D + 1, k < D + 1 - m, k < D / 2 + 2, k > n + 1, k == 0, 2'h3};
      return {k < D, k < D - m, k <= D / 2, k > n, k != 0, 2'h3};
   endfunction : exp_flags
   // Fills one past capacity so the last write is refused, then reads one
   task automatic t_fill(input logic fw, input int n, input int m);
      int f;
      int c;
      f = int'(fw);
      for (int k = 1; k <= D + 1 + f; k++) begin
         u_ffo_ctrl_model.pulse(1'b1, 4'hB, 1'b0, 9'(k));
         c = (k > D + f) ? D + f : k;
         chk(seen(fw), exp_flags(fw, c, n, m));
      end
      u_ffo_ctrl_model.pulse(1'b0, 4'hD, 1'b0, 9'h000);
      chk(seen(fw), exp_flags(fw, D + f - 1, n, m));
   endtask : t_fill
   task automatic t_offs(input int n, input int m);
      apb(1'b0, `FFO_REG_OFFSETS, 0);
      chk(rd[2*AW-1:0], {AW'(m), AW'(n)});
      for (int i = 0; i < 4; i++) begin
         u_ffo_ctrl_model.pulse(1'b0, 4'h5, 1'b0, 9'h000);
         chk(read_data_out, i[0] ? 0 : (i[1] ? m : n));
      end
   endtask : t_offs
   task automatic t_parallel();
      u_ffo_ctrl_model.mreset(1'b0, 1'b0);
      apb(1'b0, `FFO_REG_STATUS, 0);
      chk(rd[31:30], 2'b00);
      apb(1'b0, `FFO_REG_OFFSETS, 0);
      chk(rd[2*AW-1:0], {2{AW'(`FFO_OFS_DEF_PARALLEL)}});
      apb(1'b0, 12'h00C, 0);
      chk(err, 1'b1);
      for (int i = 0; i < 4; i++) begin
         u_ffo_ctrl_model.pulse(1'b1, 4'h3, 1'b0, i[0] ? 9'h000 : 9'h005);
      end
      t_offs(5, 5);
      t_fill(1'b0, 5, 5);
      apb(1'b0, `FFO_REG_STATUS, 0);
      chk(rd[30], 1'b0);
      chk(rd[15:0], 16'(D - 1));
      apb(1'b1, `FFO_REG_CTRL, 1);
      repeat (8) @(posedge ref_clk);
      chk(seen(1'b0), exp_flags(1'b0, 0, 5, 5));
      t_offs(5, 5);
   endtask : t_parallel
   task automatic t_serial();
      logic [2*AW-1:0] bits;
      bits = {AW'(3), AW'(3)};
      u_ffo_ctrl_model.mreset(1'b1, 1'b1);
      apb(1'b0, `FFO_REG_STATUS, 0);
      chk(rd[31:30], 2'b11);
      apb(1'b0, `FFO_REG_OFFSETS, 0);
      chk(rd[2*AW-1:0], {2{AW'(`FFO_OFS_DEF_SERIAL)}});
      for (int i = 0; i < 2 * AW; i++) begin
         if (i == 7) begin
            u_ffo_ctrl_model.pulse(1'b1, 4'h3, ~bits[i], 9'h0AA);
            u_ffo_ctrl_model.pulse(1'b1, 4'hE, ~bits[i], 9'h0AA);
         end
         u_ffo_ctrl_model.pulse(1'b1, 4'h6, bits[i], 9'h000);
      end
      // Both sides still wait for their two edges after the last bit
      apb(1'b0, `FFO_REG_STATUS, 0);
      chk(rd[29:28], 2'b11);
      t_offs(3, 3);
      apb(1'b0, `FFO_REG_STATUS, 0);
      chk(rd[29:28], 2'b10);
      t_fill(1'b1, 3, 3);
   endtask : t_serial
   initial begin
      {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
      repeat (5) @(posedge ref_clk);
      reset <= 1'b0;
      t_parallel();
      t_serial();
      wrap_up();
   end
endmodule : ffo_flags_bench
